/* File: logic/gces_pkg.sv */
package gces_pkg;

    // ----
    // Register map (byte addresses)
    // ----
    localparam int          ADDR_W       = 8;
    localparam int          DATA_W       = 32;
    localparam logic [7:0]  OFS_HOLD     = 8'h00;
    localparam logic [7:0]  OFS_SRQ_MASK = 8'h04;
    localparam logic [7:0]  OFS_ERR      = 8'h08;
    localparam logic [7:0]  OFS_STAT     = 8'h0c;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // ----
    // Error status word bits
    // ----
    localparam int ERR_W        = 9;
    localparam int ERR_ILL_CMD  = 0;
    localparam int ERR_ILL_OPT  = 1;
    localparam int ERR_NO_REM   = 2;
    localparam int ERR_TRG_OVR  = 3;
    localparam int ERR_CAL_VAL  = 4;
    localparam int ERR_CAL_BAD  = 5;
    localparam int ERR_CAL_LOCK = 6;
    localparam int ERR_ZERO_CHECK_CALIBRATION_FAULT = 7;
    localparam int ERR_CONFLICT = 8;
    localparam logic [ERR_W-1:0] SRQ_MASK_RST = 9'h000;

    // ----
    // Status register fields
    // ----
    localparam int STAT_REMOTE = 0;
    localparam int STAT_TALK   = 1;
    localparam int STAT_LISTEN = 2;
    localparam int STAT_SRQ    = 3;
    localparam int STAT_LLO    = 4;
    localparam int STAT_BUSY   = 5;
    localparam int STAT_DISP   = 8;
    localparam int DISP_W      = 4;
    localparam logic [DISP_W-1:0] DISP_NONE = 4'h0;

    // ----
    // Command characters
    // ----
    localparam logic [7:0]  CHAR_TERM = 8'h58;
    localparam logic [7:0]  CHAR_A    = 8'h41;
    localparam logic [7:0]  CHAR_Z    = 8'h5a;
    localparam logic [7:0]  CHAR_0    = 8'h30;
    localparam logic [7:0]  CHAR_9    = 8'h39;
    localparam logic [7:0]  CHAR_CAL  = 8'h4c;
    localparam logic [7:0]  CHAR_SRC  = 8'h56;
    localparam logic [7:0]  CHAR_FILT = 8'h50;
    localparam logic [25:0] LETTER_OK = 26'h3fffeff;
    localparam logic [3:0]  OPT_MAX   = 4'h9;
    localparam logic [3:0]  OPT_MAX_F = 4'h4;

    // ----
    // Panel keys and timing
    // ----
    localparam int KEY_W     = 8;
    localparam int KEY_LOCAL = 0;
    localparam int HOLD_W    = 16;
    localparam int CLK_MHZ   = 10;
    localparam int HOLD_US   = 500;
    localparam int HOLD_CYC  = HOLD_US * CLK_MHZ;

    typedef struct packed {
        logic [7:0] letter;
        logic [3:0] option;
    } gces_cmd_s;

    typedef enum logic [2:0] {
        P_IDLE = 3'b001,
        P_OPT  = 3'b010,
        P_SKIP = 3'b100
    } gces_pars_e;

endpackage

/* File: logic/gces_top.sv */
// Overview of operation
// - Unknown command letter raises illegal-command fault
// - After it, skip string through terminator
// - Out-of-range option raises illegal-option fault
// - After it, skip string through terminator
// - Terminator while local raises not-in-remote fault
// - Remote entered only when listen-addressed with REN
// - In remote, only local key works, but any key clears bad-cal display
// - Trigger while busy ignored, recorded, shown
// - Oversized calibration value raises magnitude fault
// - Bad cal constant kept old; shown until key
// - Guard locked: calibration ignored, fault shown
// - Source level over range ignored, fault shown
// - Enabled errors request service; word readable
// - Talker on MTA; idle on UNT/MLA/IFC
// - Listener on MLA; idle on UNL/MTA/IFC
// - Service lamp stays until poll byte read
// - Local key cancels remote, lamp, user message
// - Local lockout also disables local key
`timescale 1ns/100ps
`default_nettype none
module gces_top
    import gces_pkg::*;
#(
    parameter logic [gces_pkg::HOLD_W-1:0] HOLD_DEFAULT = gces_pkg::HOLD_W'(gces_pkg::HOLD_CYC)
) (
    // Clock and reset
    input  wire logic                          CLK_I,
    input  wire logic                          RST_I,
    // AXI4-Lite slave
    input  wire logic [gces_pkg::ADDR_W-1:0]   S_AXI_AWADDR,
    input  wire logic                          S_AXI_AWVALID,
    output logic                               S_AXI_AWREADY,
    input  wire logic [gces_pkg::DATA_W-1:0]   S_AXI_WDATA,
    input  wire logic [3:0]                    S_AXI_WSTRB,
    input  wire logic                          S_AXI_WVALID,
    output logic                               S_AXI_WREADY,
    output logic [1:0]                         S_AXI_BRESP,
    output logic                               S_AXI_BVALID,
    input  wire logic                          S_AXI_BREADY,
    input  wire logic [gces_pkg::ADDR_W-1:0]   S_AXI_ARADDR,
    input  wire logic                          S_AXI_ARVALID,
    output logic                               S_AXI_ARREADY,
    output logic [gces_pkg::DATA_W-1:0]        S_AXI_RDATA,
    output logic [1:0]                         S_AXI_RRESP,
    output logic                               S_AXI_RVALID,
    input  wire logic                          S_AXI_RREADY,
    // Bus pins (asynchronous)
    input  wire logic                          REN_I,
    input  wire logic                          IFC_I,
    // Decoded bus messages (one-cycle pulses)
    input  wire logic                          MTA_I,
    input  wire logic                          MLA_I,
    input  wire logic                          UNT_I,
    input  wire logic                          UNL_I,
    input  wire logic                          LLO_I,
    input  wire logic                          GTL_I,
    input  wire logic                          SPOLL_READ_I,
    input  wire logic                          TRIG_I,
    input  wire logic                          TRIG_DONE_I,
    // Received command characters
    input  wire logic                          CMD_VALID_I,
    input  wire logic [7:0]                    CMD_CHAR_I,
    // Instrument conditions
    input  wire logic                          CAL_OVER_I,
    input  wire logic                          ZERO_CHECK_I,
    input  wire logic                          SRC_OVER_I,
    input  wire logic                          CAL_DONE_I,
    input  wire logic                          CAL_BAD_I,
    // Panel pins (asynchronous)
    input  wire logic [gces_pkg::KEY_W-1:0]    KEYS_I,
    input  wire logic                          CAL_GUARD_I,
    // Command and action outputs
    output gces_pkg::gces_cmd_s                CMD_O,
    output logic                               CMD_VALID_O,
    output logic                               EXEC_O,
    output logic                               TRIG_GO_O,
    output logic                               READY_O,
    output logic                               CAL_COMMIT_O,
    output logic [gces_pkg::KEY_W-1:0]         KEY_PRESS_O,
    output logic                               USER_MSG_CLR_O,
    // Indicators
    output logic                               FAR_CONTROL_LAMP_O,
    output logic                               TALK_O,
    output logic                               LISTEN_INDICATOR_O,
    output logic                               SRQ_O,
    output logic [gces_pkg::DISP_W-1:0]        DISP_FAULT_O
);
    import gces_pkg::*;

    // ----
    // Pin synchronisers
    // ----
    localparam int SYN_W = KEY_W + 3;
    logic [SYN_W-1:0] syn_a;
    logic [SYN_W-1:0] syn_b;
    logic [KEY_W-1:0] key_q;

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            syn_a <= '0;
            syn_b <= '0;
            key_q <= '0;
        end else begin
            syn_a <= {CAL_GUARD_I, IFC_I, REN_I, KEYS_I};
            syn_b <= syn_a;
            key_q <= syn_b[KEY_W-1:0];
        end
    end

    logic             ren_s;
    logic             ifc_s;
    logic             guard_s;
    logic [KEY_W-1:0] key_edge;
    logic             local_ok;

    assign ren_s    = syn_b[KEY_W];
    assign ifc_s    = syn_b[KEY_W+1];
    assign guard_s  = syn_b[KEY_W+2];
    assign key_edge = syn_b[KEY_W-1:0] & ~key_q;

    // ----
    // Remote, lockout, talker, listener
    // ----
    logic remote;
    logic llo;
    logic talk;
    logic listen;

    assign local_ok = key_edge[KEY_LOCAL] & ~llo;

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            remote <= 1'b0;
        end else if (!ren_s || local_ok || GTL_I) begin
            remote <= 1'b0;
        end else if (MLA_I) begin
            remote <= 1'b1;
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            llo <= 1'b0;
        end else if (!ren_s) begin
            llo <= 1'b0;
        end else if (LLO_I) begin
            llo <= 1'b1;
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            talk <= 1'b0;
        end else if (UNT_I || MLA_I || ifc_s) begin
            talk <= 1'b0;
        end else if (MTA_I) begin
            talk <= 1'b1;
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            listen <= 1'b0;
        end else if (UNL_I || MTA_I || ifc_s) begin
            listen <= 1'b0;
        end else if (MLA_I) begin
            listen <= 1'b1;
        end
    end

    // ----
    // Command string parser
    // ----
    gces_pars_e       pstate;
    gces_pars_e       next_pstate;
    logic [7:0]       cur_letter;
    logic [ERR_W-1:0] pars_ev;
    logic             try_emit;
    logic [3:0]       try_opt;
    logic             term_ok;
    logic             is_letter;
    logic             is_digit;
    logic [3:0]       digit;
    logic [4:0]       letter_idx;

    assign is_letter  = (CMD_CHAR_I >= CHAR_A) && (CMD_CHAR_I <= CHAR_Z);
    assign is_digit   = (CMD_CHAR_I >= CHAR_0) && (CMD_CHAR_I <= CHAR_9);
    assign digit      = 4'(CMD_CHAR_I - CHAR_0);
    assign letter_idx = 5'(CMD_CHAR_I - CHAR_A);

    always_comb begin
        next_pstate = pstate;
        pars_ev     = '0;
        try_emit    = 1'b0;
        try_opt     = 4'h0;
        term_ok     = 1'b0;
        if (CMD_VALID_I) begin
            unique case (pstate)
                P_IDLE: begin
                    if (CMD_CHAR_I == CHAR_TERM) begin
                        term_ok = 1'b1;
                    end else if (is_letter && LETTER_OK[letter_idx]) begin
                        next_pstate = P_OPT;
                    end else begin
                        pars_ev[ERR_ILL_CMD] = 1'b1;
                        next_pstate          = P_SKIP;
                    end
                end
                P_OPT: begin
                    if (CMD_CHAR_I == CHAR_TERM) begin
                        try_emit    = 1'b1;
                        term_ok     = 1'b1;
                        next_pstate = P_IDLE;
                    end else if (is_digit && digit <= ((cur_letter == CHAR_FILT) ?
                                 OPT_MAX_F : OPT_MAX)) begin
                        try_emit    = 1'b1;
                        try_opt     = digit;
                        next_pstate = P_IDLE;
                    end else begin
                        pars_ev[ERR_ILL_OPT] = 1'b1;
                        next_pstate          = P_SKIP;
                    end
                end
                P_SKIP: begin
                    if (CMD_CHAR_I == CHAR_TERM) begin
                        next_pstate = P_IDLE;
                    end
                end
            endcase
        end
        if (term_ok && !remote) begin
            pars_ev[ERR_NO_REM] = 1'b1;
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            pstate     <= P_IDLE;
            cur_letter <= 8'h00;
        end else begin
            pstate <= next_pstate;
            if (pstate == P_IDLE && next_pstate == P_OPT) begin
                cur_letter <= CMD_CHAR_I;
            end
        end
    end

    // ----
    // Calibration and source checks
    // ----
    logic [ERR_W-1:0] chk_ev;
    logic             emit;

    always_comb begin
        chk_ev = '0;
        emit   = 1'b0;
        if (try_emit) begin
            if (cur_letter == CHAR_CAL) begin
                if (guard_s) begin
                    chk_ev[ERR_CAL_LOCK] = 1'b1;
                end else if (ZERO_CHECK_I) begin
                    chk_ev[ERR_ZERO_CHECK_CALIBRATION_FAULT] = 1'b1;
                end else if (CAL_OVER_I) begin
                    chk_ev[ERR_CAL_VAL] = 1'b1;
                end else begin
                    emit = 1'b1;
                end
            end else if (cur_letter == CHAR_SRC && SRC_OVER_I) begin
                chk_ev[ERR_CONFLICT] = 1'b1;
            end else begin
                emit = 1'b1;
            end
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            CMD_O       <= '0;
            CMD_VALID_O <= 1'b0;
            EXEC_O      <= 1'b0;
        end else begin
            CMD_VALID_O <= emit & remote;
            EXEC_O      <= term_ok & remote;
            if (emit) begin
                CMD_O <= '{letter: cur_letter, option: try_opt};
            end
        end
    end

    // ----
    // Trigger and calibration result
    // ----
    logic busy;
    logic trg_ovr;

    assign trg_ovr = TRIG_I & busy;

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            busy         <= 1'b0;
            TRIG_GO_O    <= 1'b0;
            CAL_COMMIT_O <= 1'b0;
        end else begin
            TRIG_GO_O    <= TRIG_I & ~busy;
            CAL_COMMIT_O <= CAL_DONE_I & ~CAL_BAD_I;
            if (TRIG_I && !busy) begin
                busy <= 1'b1;
            end else if (TRIG_DONE_I) begin
                busy <= 1'b0;
            end
        end
    end

    assign READY_O = ~busy;

    // ----
    // Error word, service request
    // ----
    logic [ERR_W-1:0]  fault_ev;
    logic [ERR_W-1:0]  err_word;
    logic [ERR_W-1:0]  err_clr;
    logic [ERR_W-1:0]  srq_mask;
    logic [HOLD_W-1:0] hold_len;
    logic              srq;

    always_comb begin
        fault_ev              = pars_ev | chk_ev;
        fault_ev[ERR_TRG_OVR] = trg_ovr;
        fault_ev[ERR_CAL_BAD] = CAL_DONE_I & CAL_BAD_I;
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            err_word <= '0;
        end else begin
            err_word <= (err_word & ~err_clr) | fault_ev;
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            srq <= 1'b0;
        end else if (|(fault_ev & srq_mask)) begin
            srq <= 1'b1;
        end else if (SPOLL_READ_I) begin
            srq <= 1'b0;
        end
    end

    // ----
    // Fault display
    // ----
    logic [DISP_W-1:0] disp;
    logic [DISP_W-1:0] next_disp;
    logic [HOLD_W-1:0] hold_cnt;

    always_comb begin
        next_disp = DISP_NONE;
        for (int i = 0; i < ERR_W; i++) begin
            if (fault_ev[i]) begin
                next_disp = DISP_W'(i + 1);
            end
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            disp     <= DISP_NONE;
            hold_cnt <= '0;
        end else if (next_disp != DISP_NONE) begin
            disp     <= next_disp;
            hold_cnt <= (hold_len == '0) ? HOLD_W'(1) : hold_len;
        end else if (disp == DISP_W'(ERR_CAL_BAD + 1)) begin
            if (|key_edge) begin
                disp <= DISP_NONE;
            end
        end else if (hold_cnt != '0) begin
            hold_cnt <= hold_cnt - HOLD_W'(1);
            if (hold_cnt == HOLD_W'(1)) begin
                disp <= DISP_NONE;
            end
        end
    end

    // ----
    // Panel key forwarding
    // ----
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            KEY_PRESS_O    <= '0;
            USER_MSG_CLR_O <= 1'b0;
        end else begin
            KEY_PRESS_O    <= remote ? '0 : key_edge;
            USER_MSG_CLR_O <= local_ok & remote;
        end
    end

    // ----
    // AXI4-Lite slave
    // ----
    logic        wr_take;
    logic        wr_hit;
    logic        rd_hit;
    logic [31:0] rd_val;

    assign wr_take       = S_AXI_AWVALID & S_AXI_WVALID & ~S_AXI_BVALID;
    assign S_AXI_AWREADY = wr_take;
    assign S_AXI_WREADY  = wr_take;
    assign S_AXI_ARREADY = ~S_AXI_RVALID;
    assign wr_hit        = (S_AXI_AWADDR == OFS_HOLD) || (S_AXI_AWADDR == OFS_SRQ_MASK) ||
                           (S_AXI_AWADDR == OFS_ERR) || (S_AXI_AWADDR == OFS_STAT);
    assign rd_hit        = (S_AXI_ARADDR == OFS_HOLD) || (S_AXI_ARADDR == OFS_SRQ_MASK) ||
                           (S_AXI_ARADDR == OFS_ERR) || (S_AXI_ARADDR == OFS_STAT);

    always_comb begin
        err_clr = '0;
        if (wr_take && S_AXI_AWADDR == OFS_ERR) begin
            err_clr = S_AXI_WDATA[ERR_W-1:0] & {{(ERR_W-8){S_AXI_WSTRB[1]}}, {8{S_AXI_WSTRB[0]}}};
        end
    end

    always_comb begin
        rd_val = 32'h0000_0000;
        unique case (S_AXI_ARADDR)
            OFS_HOLD:     rd_val[HOLD_W-1:0] = hold_len;
            OFS_SRQ_MASK: rd_val[ERR_W-1:0]  = srq_mask;
            OFS_ERR:      rd_val[ERR_W-1:0]  = err_word;
            OFS_STAT: begin
                rd_val[STAT_REMOTE]                = remote;
                rd_val[STAT_TALK]                  = talk;
                rd_val[STAT_LISTEN]                = listen;
                rd_val[STAT_SRQ]                   = srq;
                rd_val[STAT_LLO]                   = llo;
                rd_val[STAT_BUSY]                  = busy;
                rd_val[STAT_DISP +: DISP_W]        = disp;
            end
            default:      rd_val = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            hold_len <= HOLD_W'(0);
            srq_mask <= SRQ_MASK_RST;
        end else if (wr_take) begin
            if (S_AXI_AWADDR == OFS_HOLD) begin
                if (S_AXI_WSTRB[0]) begin
                    hold_len[7:0] <= S_AXI_WDATA[7:0];
                end
                if (S_AXI_WSTRB[1]) begin
                    hold_len[15:8] <= S_AXI_WDATA[15:8];
                end
            end
            if (S_AXI_AWADDR == OFS_SRQ_MASK) begin
                if (S_AXI_WSTRB[0]) begin
                    srq_mask[7:0] <= S_AXI_WDATA[7:0];
                end
                if (S_AXI_WSTRB[1]) begin
                    srq_mask[8] <= S_AXI_WDATA[8];
                end
            end
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= RESP_OKAY;
        end else if (wr_take) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA  <= 32'h0000_0000;
            S_AXI_RRESP  <= RESP_OKAY;
        end else if (S_AXI_ARVALID && !S_AXI_RVALID) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA  <= rd_val;
            S_AXI_RRESP  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    // ----
    // Indicators
    // ----
    assign FAR_CONTROL_LAMP_O = remote;
    assign TALK_O             = talk;
    assign LISTEN_INDICATOR_O = listen;
    assign SRQ_O              = srq;
    assign DISP_FAULT_O       = disp;

endmodule
`default_nettype wire

/* File: verif/gces_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module gces_chk
    import gces_pkg::*;
(
    // Watched ports
    input wire logic       CLK_I, RST_I, IFC_I, MTA_I, MLA_I, UNT_I, TRIG_I, SPOLL_READ_I,
    input wire logic       CMD_VALID_I, READY_O, TRIG_GO_O, SRQ_O, CMD_VALID_O, EXEC_O,
    input wire logic       FAR_CONTROL_LAMP_O, TALK_O, LISTEN_INDICATOR_O,
    input wire logic [7:0] CMD_CHAR_I, KEY_PRESS_O
);
    logic skip;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    // Set by an unknown letter, cleared by the terminator
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) skip <= 1'b0;
        else if (CMD_VALID_I && CMD_CHAR_I == 8'h49) skip <= 1'b1;
        else if (CMD_VALID_I && CMD_CHAR_I == CHAR_TERM) skip <= 1'b0;
    end
    sequence s_trig_busy;
        TRIG_I && !READY_O;
    endsequence
    sequence s_trig_free;
        TRIG_I && READY_O;
    endsequence
    AST_TRG_OVR: assert property (s_trig_busy |=> !TRIG_GO_O)
        else $error("overrun trigger taken");
    AST_TRG_GO: assert property (s_trig_free |=> TRIG_GO_O && !READY_O)
        else $error("free trigger lost");
    AST_SKIP: assert property ($past(skip) |-> !CMD_VALID_O && !EXEC_O)
        else $error("command after unknown letter");
    AST_REM_LSN: assert property ($rose(FAR_CONTROL_LAMP_O) |-> LISTEN_INDICATOR_O)
        else $error("remote without listen");
    AST_KEY_LOCK: assert property (FAR_CONTROL_LAMP_O && $past(FAR_CONTROL_LAMP_O)
        |-> KEY_PRESS_O == 8'h00) else $error("key seen in remote");
    AST_TALK: assert property (MTA_I && !MLA_I && !UNT_I && !IFC_I
        |=> TALK_O && !LISTEN_INDICATOR_O) else $error("talk address");
    AST_LSN: assert property (MLA_I && !MTA_I && !IFC_I
        |=> LISTEN_INDICATOR_O && !TALK_O) else $error("listen address");
    AST_SRQ_HOLD: assert property (SRQ_O && !SPOLL_READ_I |=> SRQ_O)
        else $error("service lamp dropped");
endmodule
`default_nettype wire

/* File: verif/gces_ctl.sv */
`timescale 1ns/100ps
`default_nettype none
module gces_ctl (
    // Clock
    input  wire logic  CLK_I,
    // Bus lines and decoded messages
    output logic       REN_I, IFC_I, MTA_I, MLA_I, UNT_I, UNL_I, LLO_I, GTL_I,
    output logic       SPOLL_READ_I, TRIG_I, CMD_VALID_I,
    output logic [7:0] CMD_CHAR_I
);
    logic [7:0] m;
    assign {MTA_I, MLA_I, UNT_I, UNL_I, LLO_I, GTL_I, SPOLL_READ_I, TRIG_I} = m;
    initial {REN_I, IFC_I, m, CMD_VALID_I, CMD_CHAR_I} = '0;
    // REN and IFC cross the synchroniser before any addressing follows
    task automatic ren(input logic [1:0] e);
        @(posedge CLK_I) {IFC_I, REN_I} <= e;
        repeat (3) @(posedge CLK_I);
    endtask
    task automatic msg(input logic [7:0] b);
        @(posedge CLK_I) m <= b;
        @(posedge CLK_I) m <= 8'h00;
        repeat (2) @(posedge CLK_I);
    endtask
    // Data lines show the inverse of the last character between strings
    task automatic send(input string s);
        foreach (s[i]) begin
            @(posedge CLK_I);
            {CMD_VALID_I, CMD_CHAR_I} <= {1'b1, s[i]};
        end
        @(posedge CLK_I);
        {CMD_VALID_I, CMD_CHAR_I} <= {1'b0, ~CMD_CHAR_I};
        repeat (4) @(posedge CLK_I);
    endtask
endmodule
`default_nettype wire

/* File: verif/gces_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module gces_bench;
    import gces_pkg::*;
    localparam logic [8:0] CAL_ERR [4] = '{9'h040, 9'h080, 9'h010, 9'h100};
    logic CLK_I, RST_I, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID;
    logic S_AXI_RREADY, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    logic REN_I, IFC_I, MTA_I, MLA_I, UNT_I, UNL_I, LLO_I, GTL_I, SPOLL_READ_I, TRIG_I;
    logic TRIG_DONE_I, CMD_VALID_I, CAL_OVER_I, ZERO_CHECK_I, SRC_OVER_I, CAL_DONE_I;
    logic CAL_BAD_I, CAL_GUARD_I, CMD_VALID_O, EXEC_O, TRIG_GO_O, READY_O, CAL_COMMIT_O;
    logic USER_MSG_CLR_O, FAR_CONTROL_LAMP_O, TALK_O, LISTEN_INDICATOR_O, SRQ_O;
    logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, r;
    logic [3:0]  S_AXI_WSTRB, DISP_FAULT_O, cnd;
    logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR, KEYS_I, KEY_PRESS_O, CMD_CHAR_I;
    logic [31:0] S_AXI_WDATA, S_AXI_RDATA, v, ncmd, nclr, nkey;
    gces_cmd_s   CMD_O;
    int          checked, miscompares;
    assign {CAL_GUARD_I, ZERO_CHECK_I, CAL_OVER_I, SRC_OVER_I} = cnd;
    gces_top uut (.*);
    gces_ctl ctl (.*);
    initial begin
        CLK_I = 1'b0;
        forever #50 CLK_I = ~CLK_I;
    end
    always @(posedge CLK_I) begin
        ncmd <= ncmd + CMD_VALID_O;
        nclr <= nclr + USER_MSG_CLR_O;
        nkey <= nkey + (|KEY_PRESS_O[7:1]) + CAL_COMMIT_O;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK_I);
        {S_AXI_AWADDR, S_AXI_WDATA} <= {a, d};
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'b111;
        do begin
            @(posedge CLK_I);
            if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
        end while (!S_AXI_BVALID);
        S_AXI_BREADY <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge CLK_I);
        S_AXI_ARADDR <= a;
        {S_AXI_ARVALID, S_AXI_RREADY} <= 2'b11;
        do begin
            @(posedge CLK_I);
            if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
        end while (!S_AXI_RVALID);
        S_AXI_RREADY <= 1'b0;
        {v, r} = {S_AXI_RDATA, S_AXI_RRESP};
    endtask
    task automatic cmp(input string n, input logic [31:0] g, e);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rc(input string n, input logic [7:0] a, input logic [31:0] m, e);
        rd(a);
        cmp(n, v & m, e);
    endtask
    task automatic err(input logic [8:0] e);
        rc("errors", OFS_ERR, 32'h1ff, {23'h0, e});
        wr(OFS_ERR, 32'h000001ff);
    endtask
    task automatic press(input logic [7:0] k);
        @(posedge CLK_I) KEYS_I <= k;
        repeat (5) @(posedge CLK_I);
        KEYS_I <= 8'h00;
        repeat (5) @(posedge CLK_I);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        {RST_I, S_AXI_WSTRB} = 5'h11;
        {cnd, KEYS_I, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
        {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, TRIG_DONE_I, CAL_DONE_I, CAL_BAD_I} = '0;
        {ncmd, nclr, nkey} = '0;
        repeat (5) @(posedge CLK_I);
        RST_I <= 1'b0;
        wr(OFS_HOLD, 32'h0000ffc8);
        S_AXI_WSTRB <= 4'hf;
        rc("status", OFS_STAT, 32'h3f, 32'h00);
        rd(8'h10);
        cmp("resp", {30'h0, r}, {30'h0, RESP_SLVERR});
        ctl.send("F0X");
        err(9'h004);
        ctl.ren(2'b01);
        ctl.msg(8'h40);
        rc("status", OFS_STAT, 32'h3f, 32'h05);
        ctl.send("IF0X");
        rc("display", OFS_STAT, 32'hf00, 32'h100);
        repeat (250) @(posedge CLK_I);
        rc("display", OFS_STAT, 32'hf00, 32'h000);
        err(9'h001);
        ctl.send("P5F0X");
        err(9'h002);
        cmp("commands", ncmd, 32'h0);
        ctl.send("F0X");
        cmp("commands", ncmd, 32'h1);
        ctl.msg(8'h80);
        rc("status", OFS_STAT, 32'h3f, 32'h03);
        ctl.msg(8'h20);
        ctl.msg(8'h10);
        rc("status", OFS_STAT, 32'h3f, 32'h01);
        press(8'h02);
        wr(OFS_SRQ_MASK, 32'h00000008);
        ctl.msg(8'h01);
        ctl.msg(8'h01);
        rc("status", OFS_STAT, 32'h2f, 32'h29);
        err(9'h008);
        rc("status", OFS_STAT, 32'h08, 32'h08);
        ctl.msg(8'h02);
        rc("status", OFS_STAT, 32'h08, 32'h00);
        @(posedge CLK_I) TRIG_DONE_I <= 1'b1;
        @(posedge CLK_I) TRIG_DONE_I <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            @(posedge CLK_I) cnd <= 4'h8 >> i;
            repeat (3) @(posedge CLK_I);
            ctl.send(i == 3 ? "V0X" : "L0X");
            err(CAL_ERR[i]);
        end
        @(posedge CLK_I) cnd <= 4'h0;
        ctl.msg(8'h08);
        press(8'h01);
        rc("status", OFS_STAT, 32'h11, 32'h11);
        ctl.msg(8'h84);
        ctl.ren(2'b11);
        rc("status", OFS_STAT, 32'h17, 32'h10);
        ctl.ren(2'b00);
        ctl.ren(2'b01);
        ctl.msg(8'h40);
        press(8'h01);
        rc("status", OFS_STAT, 32'h11, 32'h00);
        cmp("message clears", nclr, 32'h1);
        @(posedge CLK_I) {CAL_DONE_I, CAL_BAD_I} <= 2'b10;
        @(posedge CLK_I) {CAL_DONE_I, CAL_BAD_I} <= 2'b11;
        @(posedge CLK_I) {CAL_DONE_I, CAL_BAD_I} <= 2'b00;
        repeat (250) @(posedge CLK_I);
        rc("display", OFS_STAT, 32'hf00, 32'h600);
        press(8'h02);
        rc("display", OFS_STAT, 32'hf00, 32'h000);
        cmp("keys and commits", nkey, 32'h2);
        err(9'h020);
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge CLK_I);
        miscompares++;
        report_and_stop();
    end
endmodule
bind gces_top gces_chk chk (.*);
`default_nettype wire
